// ---- rtl/array_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface array_if #(parameter int unsigned n_in = 12, parameter int unsigned n_reg = 8);
  logic [n_in-1:0] dev_in;
  logic [n_reg-1:0] fb;
  logic [n_reg-1:0] next_state;
  modport core (output dev_in, output fb, input next_state);
  modport array (input dev_in, input fb, output next_state);
endinterface : array_if
`default_nettype wire

// ---- rtl/logic_array.sv ----
`timescale 1ns/10ps
`default_nettype none
module logic_array
  import preload_pkg::*;
#(
  parameter int unsigned n_in = 12,
  parameter int unsigned n_reg = 8
) (
  // fuse map
  input wire logic [n_reg-1:0][n_in-1:0] and_in_mask,
  input wire logic [n_reg-1:0][n_reg-1:0] and_fb_mask,
  input wire logic [n_reg-1:0] invert,
  // array ports
  array_if.array ar
);
  // one product term per register; fused-out literals drop out of the product
  function automatic logic term(input logic [n_in-1:0] v, input logic [n_in-1:0] m);
    term = &(v | ~m);
  endfunction : term

  // feedback width differs from input width, so it gets its own product
  function automatic logic term_fb(input logic [n_reg-1:0] v, input logic [n_reg-1:0] m);
    term_fb = &(v | ~m);
  endfunction : term_fb

  always_comb begin
    for (int i = 0; i < n_reg; i++) begin
      ar.next_state[i] = invert[i] ^ (term(ar.dev_in, and_in_mask[i]) &
                         term_fb(ar.fb, and_fb_mask[i]));
    end
  end
endmodule : logic_array
`default_nettype wire

// ---- rtl/preload_pkg.sv ----
package preload_pkg;
  // registered outputs and array inputs of the modelled device
  localparam int unsigned num_regs = 8;
  localparam int unsigned num_inputs = 12;
  // power-up value of every output register
  localparam logic [7:0] reg_reset_value = 8'h00;
  // preload sequencing figures, in ns, and the rate of ref_clk in MHz
  localparam int unsigned clk_mhz = 100;
  localparam int unsigned preload_min_ns = 100;
  localparam int unsigned preload_max_ns = 1000;
  localparam int unsigned preload_min_cyc = (preload_min_ns * clk_mhz + 999) / 1000;
  localparam int unsigned preload_max_cyc = (preload_max_ns * clk_mhz) / 1000;
  typedef enum logic [1:0] {
    mode_run,
    mode_preload,
    mode_exit
  } mode_t;
endpackage : preload_pkg

// ---- rtl/preload_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module preload_regs
  import preload_pkg::*;
#(
  parameter int unsigned n_in = num_inputs,
  parameter int unsigned n_reg = num_regs
) (
  // clock and power-up reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // device inputs and device clock pin, sampled on ref_clk
  input wire logic [n_in-1:0] dev_in,
  input wire logic dev_clk,
  input wire logic out_enable_b,
  // preload control pin at preload_high_voltage_level
  input wire logic preload_en,
  // fuse map
  input wire logic [n_reg-1:0][n_in-1:0] and_in_mask,
  input wire logic [n_reg-1:0][n_reg-1:0] and_fb_mask,
  input wire logic [n_reg-1:0] invert,
  // registered output pins
  input wire logic [n_reg-1:0] q_pin_in,
  output logic [n_reg-1:0] q_pin_out,
  output logic [n_reg-1:0] q_pin_oe,
  // combinational output, untouched by the power-up clear; preload status, cleared by it
  output logic comb_out,
  output logic preload_active
);
  if (n_reg < 1 || n_reg > 8 || n_in < 1) begin : g_bad_size
    $error("preload_regs: unsupported size");
  end

  array_if #(.n_in(n_in), .n_reg(n_reg)) ar ();

  logic [n_reg-1:0] state_q, state_d;
  logic [n_reg-1:0] oe_q, oe_d;
  logic clk_q, clk_d;
  logic comb_q, comb_d;
  mode_t mode_q, mode_d;
  logic active_q, active_d;
  logic rise;

  assign ar.dev_in = dev_in;
  assign ar.fb = state_q;
  assign rise = dev_clk & ~clk_q;

  logic_array #(.n_in(n_in), .n_reg(n_reg)) u_array (
    .and_in_mask(and_in_mask),
    .and_fb_mask(and_fb_mask),
    .invert(invert),
    .ar(ar)
  );

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    clk_d = dev_clk;
    // pins float during preload so the tester can force them
    oe_d = (preload_en || out_enable_b) ? '0 : '1;
    comb_d = ^dev_in;
    case (mode_q)
      mode_run: begin
        if (preload_en) begin
          mode_d = mode_preload;
        end else if (rise) begin
          state_d = ar.next_state;
        end
      end
      mode_preload: begin
        // every register sees its own pin; the tester moves one pin at a time
        if (rise) begin
          state_d = q_pin_in;
        end
        if (!preload_en) begin
          mode_d = mode_exit;
        end
      end
      mode_exit: begin
        mode_d = mode_run;
      end
      default: begin
        mode_d = mode_run;
      end
    endcase
    // registered so the status pin never glitches on a mode decode
    active_d = (mode_d != mode_run);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= reg_reset_value[n_reg-1:0];
      oe_q <= '0;
      clk_q <= 1'b0;
      mode_q <= mode_run;
      active_q <= 1'b0;
    end else begin
      state_q <= state_d;
      oe_q <= oe_d;
      clk_q <= clk_d;
      mode_q <= mode_d;
      active_q <= active_d;
    end
  end

  // no reset here: the clear leaves combinational outputs alone
  always_ff @(posedge ref_clk) begin
    comb_q <= comb_d;
  end

  assign q_pin_out = state_q;
  assign q_pin_oe = oe_q;
  assign comb_out = comb_q;
  assign preload_active = active_q;
endmodule : preload_regs
`default_nettype wire

// ---- testbench/preload_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module preload_chk (
  // watched pins
  input wire logic ref_clk, rst_b, dev_clk, out_enable_b, comb_out, preload_active,
  input wire logic [11:0] dev_in,
  input wire logic [7:0] q_pin_in, q_pin_out, q_pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence rise_s;
    dev_clk && !$past(dev_clk);
  endsequence
  sequence exit_s;
    preload_active ##1 !preload_active;
  endsequence
  a_reset_clear: assert property (disable iff (1'b0) !rst_b |-> q_pin_out == 8'h00) else $error("no clear");
  a_comb_free: assert property (disable iff (1'b0) !rst_b ##1 !rst_b |-> comb_out == ^$past(dev_in))
    else $error("comb hit");
  a_preload_load: assert property (preload_active ##0 rise_s |-> ##[1:2] q_pin_out == q_pin_in) else $error("no load");
  // a late update would show up here, well after the clock pin fell
  a_run_hold: assert property (!dev_clk [*3] |-> $stable(q_pin_out)) else $error("q moved");
  a_oe_off: assert property (out_enable_b [*2] |-> q_pin_oe == 8'h00) else $error("oe on");
  a_exit_keep: assert property (exit_s |-> $stable(q_pin_out)) else $error("exit moved");
endmodule : preload_chk
bind preload_regs preload_chk u_chk(.ref_clk, .rst_b, .dev_clk, .out_enable_b, .comb_out, .preload_active, .dev_in,
  .q_pin_in, .q_pin_out, .q_pin_oe);
`default_nettype wire

// ---- testbench/register_preload_powerup_reset_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module register_preload_powerup_reset_bench;
  import preload_pkg::*;
  logic ref_clk = 0, rst_b = 0, dev_clk = 0, oe_b = 0, pre = 0, frc = 0, bitv = 0;
  logic [2:0] idx = 0;
  logic [11:0] din = 0;
  logic [7:0][11:0] mi = 0;
  logic [7:0][7:0] mf = 0;
  logic [7:0] inv = 0, pin, qo, qoe, eq = 0, que[$];
  logic co, pa;
  int fails = 0, checks = 0;
  always #5 ref_clk = ~ref_clk;
  preload_regs u_dut(.ref_clk, .rst_b, .dev_in(din), .dev_clk, .out_enable_b(oe_b), .preload_en(pre), .and_in_mask(mi),
    .and_fb_mask(mf), .invert(inv), .q_pin_in(pin), .q_pin_out(qo), .q_pin_oe(qoe), .comb_out(co),
    .preload_active(pa));
  tester_pins u_pins(.frc, .bitv, .idx, .q_pin_out(qo), .q_pin_oe(qoe), .q_pin_in(pin));
  task chk(input logic [7:0] s, input logic [7:0] w);
    checks++;
    if (s !== w) begin
      fails++;
      $display("unexpected %0t %h %h", $time, s, w);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  task pulse;
    que.push_back(eq);
    dev_clk <= 1;
    wt(preload_min_cyc);
    dev_clk <= 0;
    wt(preload_min_cyc);
  endtask : pulse
  function automatic logic [7:0] nxt;
    for (int i = 0; i < 8; i++) nxt[i] = inv[i] ^ (&(din | ~mi[i]) & &(eq | ~mf[i]));
  endfunction : nxt
  always @(negedge dev_clk) begin
    @(negedge ref_clk);
    chk(qo, que.pop_front());
  end
  initial begin
    void'($urandom(996));
    repeat (12) begin
      @(posedge ref_clk);
      din <= 12'($urandom);
    end
    chk(qo, 8'h00);
    rst_b <= 1;
    mi <= {3{$urandom & $urandom & $urandom}};
    mf <= {2{$urandom & $urandom}};
    inv <= 8'($urandom);
    wt(preload_min_cyc);
    repeat (20) begin
      din <= 12'($urandom);
      oe_b <= 1'($urandom);
      wt(1);
      eq = nxt();
      pulse();
      chk({7'h00, co}, {7'h00, ^din});
    end
    oe_b <= 0;
    for (int i = 0; i < 8; i++) begin
      pre <= 1;
      wt(preload_min_cyc);
      chk({7'h00, pa}, 8'h01);
      idx <= 3'(i);
      bitv <= 1'($urandom);
      frc <= 1;
      wt(preload_min_cyc);
      eq[i] = bitv;
      pulse();
      frc <= 0;
      wt(preload_min_cyc);
      pre <= 0;
      wt(12);
      chk(pin, eq);
    end
    oe_b <= 1;
    wt(3);
    chk(qoe, 8'h00);
    rst_b <= 0;
    wt(2);
    chk(qo, 8'h00);
    chk({7'h00, co}, {7'h00, ^din});
    stop_test();
  end
  initial begin
    #50us;
    fails++;
    stop_test();
  end
endmodule : register_preload_powerup_reset_bench
`default_nettype wire

// ---- testbench/tester_pins.sv ----
`timescale 1ns/10ps
`default_nettype none
module tester_pins (
  input wire logic frc, bitv,
  input wire logic [2:0] idx,
  input wire logic [7:0] q_pin_out, q_pin_oe,
  output logic [7:0] q_pin_in
);
  // released pins float to the pull-up; untargeted pins are held at their state
  always_comb begin
    for (int i = 0; i < 8; i++) q_pin_in[i] = frc ? (i == idx ? bitv : q_pin_out[i]) : (q_pin_oe[i] ? q_pin_out[i] : 1'b1);
  end
endmodule : tester_pins
`default_nettype wire
